// ---- hdl/sar_adc_cal_serial_control.sv ----
// Notes on behaviour
// - Calibration request high resets logic, raises busy, aborts any activity.
// - Calibration starts on request fall, ends within fewer than 5000 clocks.
// - During calibration data shows diagnostics if sample low, low if high.
// - Sample input does not influence calibration progress.
// - Busy falling marks end of calibration.
// - Conversion is acquisition then exactly 17 master clock pulses.
// - Sample falling edge holds input, commits; sample ignored until busy low.
// - Busy rises after first rising clock edge, falls after the 17th.
// - Data and bit strobe change only on valid master clock pulses.
// - Result MSB first, twos complement; MSB valid at second strobe rise.
// - Once busy is low, clock ignored and outputs held until acquisition; the strobe still falls with the last pulse.
// - Sample already high when busy falls starts acquisition immediately.
// - Codes: negative full scale 100..0, midscale 000..0, positive 011..1.
// - Calibration request is taken asynchronously to the master clock.
// - Bit strobe is derived from the master clock.
module sar_adc_cal_serial_control
    import sar_cal_pkg::*;
#(
    parameter int CAL_PULSES = CAL_PULSES_DEF
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_conv_clk,
    input wire logic i_sample,
    input wire logic i_cal,
    input wire logic i_comp_hi,
    output logic o_busy,
    output logic o_dout,
    output logic o_dout_clk,
    output logic o_track,
    output logic [sar_cal_pkg::RESULT_W-1:0] o_trial
);
    import sar_cal_pkg::*;

    localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_PULSES);

    logic rst_meta_reg;
    logic rst_n_reg;
    logic cal_meta_reg;
    logic cal_sync_reg;
    logic conv_clk_d_reg;
    logic conv_rise;
    logic conv_fall;
    ctrl_state_e state_reg;
    logic [4:0] pulse_cnt_reg;
    logic [CAL_CNT_W-1:0] cal_cnt_reg;
    logic busy_reg;
    logic dout_reg;
    logic dout_clk_reg;
    logic trail_reg;
    logic track_reg;
    logic sar_start;
    logic sar_step;
    logic [RESULT_W-1:0] trial;

    // Reset release through two flops
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cal_meta_reg <= 1'b0;
            cal_sync_reg <= 1'b0;
        end else begin
            cal_meta_reg <= i_cal;
            cal_sync_reg <= cal_meta_reg;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            conv_clk_d_reg <= 1'b0;
        end else begin
            conv_clk_d_reg <= i_conv_clk;
        end
    end

    assign conv_rise = i_conv_clk && !conv_clk_d_reg;
    assign conv_fall = !i_conv_clk && conv_clk_d_reg;

    // Sequencer
    always_ff @(posedge i_mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= ST_IDLE;
            pulse_cnt_reg <= '0;
            cal_cnt_reg <= '0;
        end else if (cal_sync_reg) begin
            state_reg <= ST_CAL_HOLD;
            pulse_cnt_reg <= '0;
            cal_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    // clock ignored; sample high starts acquisition
                    if (i_sample) begin
                        state_reg <= ST_ACQUIRE;
                    end
                end
                ST_ACQUIRE: begin
                    if (!i_sample) begin
                        state_reg <= ST_CONVERT;
                        pulse_cnt_reg <= '0;
                    end
                end
                ST_CONVERT: begin
                    if (conv_rise) begin
                        if (pulse_cnt_reg == CONV_PULSES - 5'h01) begin
                            state_reg <= i_sample ? ST_ACQUIRE : ST_IDLE;
                            pulse_cnt_reg <= '0;
                        end else begin
                            pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
                        end
                    end
                end
                ST_CAL_HOLD: begin
                    state_reg <= ST_CAL_RUN;
                    cal_cnt_reg <= '0;
                end
                ST_CAL_RUN: begin
                    // sample has no say in progress
                    if (conv_rise) begin
                        if (cal_cnt_reg == CAL_LAST - 1'b1) begin
                            state_reg <= i_sample ? ST_ACQUIRE : ST_IDLE;
                        end
                        cal_cnt_reg <= cal_cnt_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    // busy after first and 17th edges; calibration busy
    always_ff @(posedge i_mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            busy_reg <= BUSY_RST;
        end else if (cal_sync_reg || state_reg == ST_CAL_HOLD) begin
            busy_reg <= 1'b1;
        end else if (state_reg == ST_CAL_RUN) begin
            busy_reg <= !(conv_rise && cal_cnt_reg == CAL_LAST - 1'b1);
        end else if (state_reg == ST_CONVERT && conv_rise) begin
            busy_reg <= (pulse_cnt_reg != CONV_PULSES - 5'h01);
        end
    end

    assign sar_start = (state_reg == ST_CONVERT) && conv_rise && (pulse_cnt_reg == 5'h00);
    assign sar_step = (state_reg == ST_CONVERT) && conv_rise && (pulse_cnt_reg != 5'h00);

    // data only on valid pulses; MSB inverted for twos complement
    always_ff @(posedge i_mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            dout_reg <= DOUT_RST;
        end else if (cal_sync_reg) begin
            dout_reg <= DOUT_RST;
        end else if (state_reg == ST_CAL_RUN && conv_rise) begin
            dout_reg <= i_sample ? 1'b0 : cal_cnt_reg[DIAG_BIT];
        end else if (sar_step) begin
            dout_reg <= (pulse_cnt_reg == 5'h01) ? !i_comp_hi : i_comp_hi;
        end
    end

    // strobe follows valid master clock pulses
    always_ff @(posedge i_mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            dout_clk_reg <= 1'b0;
            trail_reg <= 1'b0;
        end else if (cal_sync_reg) begin
            dout_clk_reg <= 1'b0;
            trail_reg <= 1'b0;
        end else if ((state_reg == ST_CONVERT || state_reg == ST_CAL_RUN) && conv_rise) begin
            dout_clk_reg <= 1'b1;
            trail_reg <= 1'b1;
        end else if (conv_fall && trail_reg) begin
            // Low phase of the last valid pulse still ends the strobe
            dout_clk_reg <= 1'b0;
            trail_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            track_reg <= 1'b0;
        end else begin
            track_reg <= !cal_sync_reg && state_reg == ST_ACQUIRE && i_sample;
        end
    end

    sar_register #(
        .WIDTH(RESULT_W)
    ) u_sar (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n_reg),
        .i_start(sar_start),
        .i_step(sar_step),
        .i_comp_hi(i_comp_hi),
        .o_trial(trial),
        .o_result()
    );

    assign o_busy = busy_reg;
    assign o_dout = dout_reg;
    assign o_dout_clk = dout_clk_reg;
    assign o_track = track_reg;
    assign o_trial = trial;

endmodule

// ---- hdl/sar_cal_pkg.sv ----
package sar_cal_pkg;

    // Result width of the successive-approximation sequence
    localparam int RESULT_W = 16;
    // Master clock pulses per conversion
    localparam logic [4:0] CONV_PULSES = 5'h11;
    // Calibration must end in fewer master clock pulses than this
    localparam int CAL_PULSE_LIMIT = 5000;
    // Default calibration length in master clock pulses (below the limit)
    localparam int CAL_PULSES_DEF = CAL_PULSE_LIMIT - 1;
    localparam int CAL_CNT_W = 13;
    // Least calibration request hold, in master clock cycles (host side)
    localparam int CAL_HOLD_MIN = 4;
    // Reset values
    localparam logic BUSY_RST = 1'b0;
    localparam logic DOUT_RST = 1'b0;
    localparam logic [RESULT_W-1:0] TRIAL_RST = 16'h0000;
    // Bit of the calibration counter shown as diagnostic data
    localparam int DIAG_BIT = 3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACQUIRE,
        ST_CONVERT,
        ST_CAL_HOLD,
        ST_CAL_RUN
    } ctrl_state_e;

endpackage

// ---- hdl/sar_register.sv ----
// Successive-approximation register: one trial bit per step
module sar_register
    import sar_cal_pkg::*;
#(
    parameter int WIDTH = RESULT_W
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic i_step,
    input wire logic i_comp_hi,
    output logic [WIDTH-1:0] o_trial,
    output logic [WIDTH-1:0] o_result
);
    import sar_cal_pkg::*;

    logic [WIDTH-1:0] trial_reg;
    logic [WIDTH-1:0] mask_reg;

    assign o_trial = trial_reg;
    assign o_result = trial_reg;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trial_reg <= WIDTH'(TRIAL_RST);
            mask_reg <= '0;
        end else if (i_start) begin
            trial_reg <= {1'b1, {(WIDTH-1){1'b0}}};
            mask_reg <= {1'b1, {(WIDTH-1){1'b0}}};
        end else if (i_step && (mask_reg != '0)) begin
            // Keep or drop the bit on trial, then try the next one
            trial_reg <= (i_comp_hi ? trial_reg : (trial_reg & ~mask_reg)) | (mask_reg >> 1);
            mask_reg <= mask_reg >> 1;
        end
    end

endmodule

// ---- tb/sar_adc_cal_serial_control_assertions.sv ----
module sar_adc_cal_serial_control_assertions
    import sar_cal_pkg::*;
#(
    parameter int CAL_PULSES = CAL_PULSES_DEF
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_conv_clk,
    input wire logic i_sample,
    input wire logic i_cal,
    input wire logic o_busy,
    input wire logic o_dout,
    input wire logic o_dout_clk,
    input wire logic o_track
);
    timeunit 1ns;
    timeprecision 1ps;
    logic conv_q;
    logic busy_q;
    logic in_cal;
    logic rise;
    int cnt;
    assign rise = i_conv_clk && !conv_q;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            conv_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            conv_q <= i_conv_clk;
            busy_q <= o_busy;
        end
    end
    // From request until busy falls
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) in_cal <= 1'b0;
        else if (i_cal) in_cal <= 1'b1;
        else if (busy_q && !o_busy) in_cal <= 1'b0;
    end
    // Pulses seen while busy
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) cnt <= 0;
        else if (i_cal || !o_busy) cnt <= 0;
        else if (rise) cnt <= cnt + 1;
    end
    default clocking dc @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    a_cal_sets_busy: assert property (i_cal [*4] |=> o_busy)
        else $error("busy low after calibration request");
    a_cal_clears_out: assert property (i_cal [*4] |=> !o_dout && !o_dout_clk)
        else $error("outputs not cleared by calibration request");
    a_cal_busy_held: assert property (o_busy && i_cal && $past(i_cal) && $past(i_cal, 2)
        |=> o_busy)
        else $error("busy dropped during calibration request");
    a_busy_pulse_count: assert property ($fell(o_busy)
        |-> (in_cal ? cnt == CAL_PULSES : cnt == 16))
        else $error("busy fell after wrong pulse count");
    a_busy_rise_cause: assert property ($rose(o_busy) && !in_cal |-> $past(rise) || $past(rise, 2))
        else $error("busy rose without a clock pulse");
    a_strobe_from_clock: assert property ($rose(o_dout_clk) |-> $past(rise) || $past(rise, 2))
        else $error("strobe rose without a clock pulse");
    a_dout_on_pulse: assert property ($changed(o_dout) && !in_cal |-> $past(rise) || $past(rise, 2))
        else $error("data changed without a clock pulse");
    a_cal_dout_low: assert property (in_cal && rise && i_sample ##1 i_sample |=> !o_dout)
        else $error("data not low in calibration with sample high");
    a_idle_hold: assert property ((!o_busy && !o_track && !in_cal) [*2] |-> $stable(o_dout))
        else $error("data changed while idle");
    a_track_after_busy: assert property ($fell(o_busy) && i_sample && !in_cal |-> ##[0:2] o_track)
        else $error("no acquisition when busy fell with sample high");
    cover property ($fell(o_busy) && !in_cal && !i_sample);
    cover property ($fell(o_busy) && in_cal);
    cover property ($fell(o_busy) && i_sample && !in_cal);
endmodule
bind sar_adc_cal_serial_control sar_adc_cal_serial_control_assertions #(.CAL_PULSES(CAL_PULSES))
    sar_adc_cal_serial_control_assertions_i (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_conv_clk(i_conv_clk), .i_sample(i_sample), .i_cal(i_cal), .o_busy(o_busy),
    .o_dout(o_dout), .o_dout_clk(o_dout_clk), .o_track(o_track));

// ---- tb/sar_adc_cal_serial_control_tb_top.sv ----
module sar_adc_cal_serial_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_cal_pkg::*;
    localparam int CAL_P = 16;
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_conv_clk = 1'b0;
    logic i_sample = 1'b0;
    logic i_cal = 1'b0;
    logic comp_hi;
    logic o_busy, o_dout, o_dout_clk, o_track;
    logic [RESULT_W-1:0] o_trial;
    logic [RESULT_W-1:0] level = 16'h0000;
    logic [RESULT_W-1:0] word;
    logic [RESULT_W-1:0] corners [5] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'h8001};
    int bad_count = 0;
    int compares = 0;
    int seed = 32'hd602;
    always #20 i_mclk = ~i_mclk;
    sar_adc_cal_serial_control #(.CAL_PULSES(CAL_P)) sar_adc_cal_serial_control_i (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_conv_clk(i_conv_clk), .i_sample(i_sample),
        .i_cal(i_cal), .i_comp_hi(comp_hi), .o_busy(o_busy), .o_dout(o_dout),
        .o_dout_clk(o_dout_clk), .o_track(o_track), .o_trial(o_trial));
    sar_front_model sar_front_model_i (.i_level(level), .i_trial(o_trial), .o_comp_hi(comp_hi));
    function automatic logic [15:0] exp_code(input logic [15:0] lv);
        return lv ^ 16'h8000;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    task automatic pulse(output logic d, output logic s, output logic b);
        i_conv_clk = 1'b1;
        wait_n(3);
        d = o_dout;
        s = o_dout_clk;
        b = o_busy;
        i_conv_clk = 1'b0;
        wait_n(3);
    endtask
    task automatic convert(input logic [15:0] lv, input bit poke, input bit stay);
        logic d, s, b, d0, s0;
        level = lv;
        i_sample = 1'b1;
        wait_n(4);
        check("track", o_track, 1'b1);
        i_sample = 1'b0;
        wait_n(3);
        for (int k = 1; k <= 17; k++) begin
            if (poke) i_sample = (k > 5 && k < 9);
            if (stay && k == 17) i_sample = 1'b1;
            pulse(d, s, b);
            if (k > 1) word = {word[14:0], d};
            if (k == 1) check("trial start", o_trial, 16'h8000);
            check("strobe", s, 1'b1);
            check("busy", b, k < 17);
        end
        check("result", word, exp_code(lv));
        check("track after", o_track, stay);
        if (!stay) begin
            d0 = o_dout;
            s0 = o_dout_clk;
            pulse(d, s, b);
            check("idle data", {d, s, b}, {d0, s0, 1'b0});
        end
    endtask
    task automatic calibrate(input bit abort);
        logic d, s, b;
        if (abort) begin
            i_sample = 1'b1;
            wait_n(4);
            i_sample = 1'b0;
            wait_n(3);
            repeat (5) pulse(d, s, b);
        end
        i_cal = 1'b1;
        wait_n(5);
        check("cal busy", o_busy, 1'b1);
        check("cal clear", {o_dout, o_dout_clk}, 2'b00);
        i_cal = 1'b0;
        wait_n(4);
        for (int k = 1; k <= CAL_P; k++) begin
            i_sample = k[0];
            pulse(d, s, b);
            check("cal strobe", s, 1'b1);
            if (k[0]) check("cal dout", d, 1'b0);
            else check("cal diag", d, 16'(((k - 1) >> DIAG_BIT) & 1));
            check("cal busy run", b, k < CAL_P);
        end
        i_sample = 1'b0;
        check("cal end", o_busy, 1'b0);
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_mclk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        wait_n(20);
        i_nrst = 1'b1;
        wait_n(5);
        foreach (corners[i]) convert(corners[i], 1'b0, 1'b0);
        repeat (12) convert($random(seed), $random(seed) % 2 != 0, $random(seed) % 2 != 0);
        calibrate(1'b0);
        convert($random(seed), 1'b0, 1'b0);
        calibrate(1'b1);
        convert($random(seed), 1'b1, 1'b1);
        tally_and_finish();
    end
endmodule

// ---- tb/sar_front_model.sv ----
module sar_front_model
    import sar_cal_pkg::*;
(
    input wire logic [RESULT_W-1:0] i_level,
    input wire logic [RESULT_W-1:0] i_trial,
    output logic o_comp_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_comp_hi = (i_level >= i_trial);
endmodule
